// ===== rtl/vmc_map.vh
// Purpose: Offsets, field positions and reset values of the mode-control bank
// Assumes: Eight-bit registers reached by subaddress over the serial bus
// Notes: Included by every file of the bank
`ifndef VMC_MAP_VH
`define VMC_MAP_VH
// Subaddresses
`define VMC_ADDR_ONE 8'h01
`define VMC_ADDR_TWO 8'h02
`define VMC_ADDR_THREE 8'h03
`define VMC_ADDR_FOUR 8'h04
// Reset values
`define VMC_RST_ONE 8'h00
`define VMC_RST_TWO 8'h00
`define VMC_RST_THREE 8'h00
`define VMC_RST_FOUR 8'h00
// Default revision, arbitrary value
`define VMC_REVISION 2'h0
// Register one fields
`define VMC_B_DAC_C_OFF 3
`define VMC_B_DAC_D_OFF 4
`define VMC_B_DAC_B_OFF 5
`define VMC_B_DAC_A_OFF 6
`define VMC_B_COLOR_BAR 7
// Register two fields
`define VMC_B_SQUARE_PIXEL 0
`define VMC_B_GENLOCK_IN 1
`define VMC_B_GENLOCK_ROLE 2
`define VMC_B_ACTIVE_LINE 3
`define VMC_B_CHROMA 4
`define VMC_B_BURST 5
`define VMC_B_LOW_POWER 6
`define VMC_B_RSVD_TWO 7
// Register three fields
`define VMC_B_REV_LO 0
`define VMC_B_REV_HI 1
`define VMC_B_VBI_PASS 2
`define VMC_B_EUROSCART 3
`define VMC_B_CHROMA_OUT 4
`define VMC_B_TTX_ENABLE 5
`define VMC_B_TTX_STYLE 6
`define VMC_B_DEFAULT_COLOR 7
// Register four fields
`define VMC_B_COMPONENT 0
`define VMC_B_YUV 1
`define VMC_B_SYNC_RGB 2
`define VMC_B_LONG_VSYNC 3
`define VMC_B_PEDESTAL 4
`define VMC_B_FILTER_SW 5
`define VMC_B_SLEEP 6
`define VMC_B_RSVD_FOUR 7
// Active line lengths in pixels
`define VMC_LINE_FULL 10'd720
`define VMC_LINE_NTSC 10'd710
`define VMC_LINE_PAL 10'd702
// Vertical sync lengths in half lines
`define VMC_VS_NORMAL 3'd0
`define VMC_VS_NTSC 3'd6
`define VMC_VS_PAL 3'd5
// DAC source codes
`define VMC_SRC_COMPOSITE_VIDEO 3'd0
`define VMC_SRC_Y 3'd1
`define VMC_SRC_C 3'd2
`define VMC_SRC_R_V 3'd3
`define VMC_SRC_G 3'd4
`define VMC_SRC_B_U 3'd5
`endif

// ===== rtl/vmc_reg8.v
// Purpose: One eight-bit mode register with a write strobe
// Assumes: Writes are single-cycle strobes synchronous to clk
// Notes: Bits in keep_mask hold reset value and ignore writes
`timescale 1ns/1ns
`include "vmc_map.vh"
module vmc_reg8
#(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] KEEP_MASK = 8'h00
)
(
  input wire clk,
  input wire nrst,
  input wire wr_en,
  input wire [7:0] wr_data,
  output wire [7:0] q
);
  reg [7:0] val_reg;
  // Store written bits, masked bits stay at reset value
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      val_reg <= RESET_VAL;
    else if (wr_en)
      val_reg <= (wr_data & ~KEEP_MASK) | (RESET_VAL & KEEP_MASK);
  end
  assign q = val_reg;
endmodule // vmc_reg8

// ===== rtl/vmc_genlock_edge.v
// Purpose: Falling edge detect on the shared genlock pin
// Assumes: Pin input is synchronous to clk
// Notes: Pulse only when the pin is a subcarrier reset input
`timescale 1ns/1ns
`include "vmc_map.vh"
module vmc_genlock_edge
(
  input wire clk,
  input wire nrst,
  input wire pin_in,
  input wire armed,
  output wire fall_pulse
);
  reg last_reg;
  // Remember last level, idle high
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      last_reg <= 1'b1;
    else
      last_reg <= pin_in;
  end
  assign fall_pulse = armed & last_reg & ~pin_in;
endmodule // vmc_genlock_edge

// ===== rtl/vmc_mode_bank.v
// Purpose: Mode-control register bank of a PAL/NTSC video encoder
// Assumes: Serial bus front end delivers subaddress, data and strobes
// Notes: All control outputs are registered decodes of the bank
`timescale 1ns/1ns
`include "vmc_map.vh"
module vmc_mode_bank
(
  input wire clk,
  input wire nrst,
  input wire [7:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [1:0] revision_in,
  input wire pal_mode,
  input wire master_timing,
  input wire genlock_pin_in,
  input wire teletext_input_pin,
  input wire teletext_window,
  input wire teletext_bit_tick,
  input wire pixel_zero,
  input wire in_active_video,
  input wire in_vbi,
  output reg [7:0] bus_rdata,
  output reg bus_ack,
  output reg [3:0] dac_powerdown_bits,
  output reg color_bar_enable,
  output reg force_master,
  output reg square_pixel_enable,
  output reg genlock_pin_oe,
  output reg genlock_rtc_in,
  output reg subcarrier_reset,
  output reg [9:0] active_line_pixels,
  output reg chroma_enable,
  output reg burst_enable,
  output reg low_power_enable,
  output reg vbi_blank,
  output reg teletext_data,
  output reg teletext_request,
  output reg force_black,
  output reg sync_on_component,
  output reg [2:0] vsync_half_lines,
  output reg pedestal_on,
  output reg blank_filter_on,
  output reg sleep_enable,
  output reg [2:0] dac_a_src,
  output reg [2:0] dac_b_src,
  output reg [2:0] dac_c_src,
  output reg [2:0] dac_d_src
);
  localparam [7:0] REV_MASK = 8'h03;
  wire [7:0] mr_one;
  wire [7:0] mr_two;
  wire [7:0] mr_three_raw;
  wire [7:0] mr_four;
  wire [7:0] mr_three;
  wire we_one;
  wire we_two;
  wire we_three;
  wire we_four;
  wire sc_fall;
  wire genlock_in;
  wire scart;
  wire comp;
  wire yuv;
  wire chroma_sel;
  reg [2:0] a_next;
  reg [2:0] b_next;
  reg [2:0] c_next;
  reg [2:0] d_next;
  reg [7:0] rdata_next;
  reg addr_ok;

  // Write strobes per subaddress
  assign we_one = bus_wr & (bus_addr == `VMC_ADDR_ONE);
  assign we_two = bus_wr & (bus_addr == `VMC_ADDR_TWO);
  assign we_three = bus_wr & (bus_addr == `VMC_ADDR_THREE);
  assign we_four = bus_wr & (bus_addr == `VMC_ADDR_FOUR);

  // Register storage; registers stay live during sleep
  vmc_reg8 #(.RESET_VAL(`VMC_RST_ONE), .KEEP_MASK(8'h00)) u_one
  (
    .clk(clk),
    .nrst(nrst),
    .wr_en(we_one),
    .wr_data(bus_wdata),
    .q(mr_one)
  );
  vmc_reg8 #(.RESET_VAL(`VMC_RST_TWO), .KEEP_MASK(8'h00)) u_two
  (
    .clk(clk),
    .nrst(nrst),
    .wr_en(we_two),
    .wr_data(bus_wdata),
    .q(mr_two)
  );
  vmc_reg8 #(.RESET_VAL(`VMC_RST_THREE), .KEEP_MASK(REV_MASK)) u_three
  (
    .clk(clk),
    .nrst(nrst),
    .wr_en(we_three),
    .wr_data(bus_wdata),
    .q(mr_three_raw)
  );
  vmc_reg8 #(.RESET_VAL(`VMC_RST_FOUR), .KEEP_MASK(8'h00)) u_four
  (
    .clk(clk),
    .nrst(nrst),
    .wr_en(we_four),
    .wr_data(bus_wdata),
    .q(mr_four)
  );

  // Revision bits come from the device, not from storage
  assign mr_three = {mr_three_raw[7:2], revision_in};

  // Genlock pin falling edge while configured as subcarrier reset
  assign genlock_in = mr_two[`VMC_B_GENLOCK_IN];
  vmc_genlock_edge u_edge
  (
    .clk(clk),
    .nrst(nrst),
    .pin_in(genlock_pin_in),
    .armed(genlock_in & ~mr_two[`VMC_B_GENLOCK_ROLE]),
    .fall_pulse(sc_fall)
  );

  assign scart = mr_three[`VMC_B_EUROSCART];
  assign comp = mr_four[`VMC_B_COMPONENT];
  assign yuv = mr_four[`VMC_B_YUV];
  assign chroma_sel = mr_three[`VMC_B_CHROMA_OUT];

  // DAC routing matrix
  always @*
  begin
    if (!comp)
    begin
      a_next = scart ? `VMC_SRC_Y : `VMC_SRC_COMPOSITE_VIDEO;
      b_next = `VMC_SRC_COMPOSITE_VIDEO;
      c_next = `VMC_SRC_C;
      d_next = scart ? `VMC_SRC_COMPOSITE_VIDEO : `VMC_SRC_Y;
    end
    else
    begin
      a_next = scart ? (yuv ? `VMC_SRC_Y : `VMC_SRC_G) : `VMC_SRC_COMPOSITE_VIDEO;
      b_next = `VMC_SRC_B_U;
      c_next = `VMC_SRC_R_V;
      d_next = scart ? `VMC_SRC_COMPOSITE_VIDEO : (yuv ? `VMC_SRC_Y : `VMC_SRC_G);
    end
    // Chroma takes the composite converter's place
    if (chroma_sel)
    begin
      if (scart)
        d_next = `VMC_SRC_C;
      else
        a_next = `VMC_SRC_C;
    end
  end

  // Read mux; revision on low bits of register three
  always @*
  begin
    addr_ok = 1'b1;
    case (bus_addr)
      `VMC_ADDR_ONE: rdata_next = mr_one;
      `VMC_ADDR_TWO: rdata_next = mr_two;
      `VMC_ADDR_THREE: rdata_next = mr_three;
      `VMC_ADDR_FOUR: rdata_next = mr_four;
      default:
      begin
        rdata_next = 8'h00;
        addr_ok = 1'b0;
      end
    endcase
  end

  // Bus answers, one cycle after the strobe
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_rdata <= 8'h00;
      bus_ack <= 1'b0;
    end
    else
    begin
      bus_ack <= (bus_wr | bus_rd) & addr_ok;
      if (bus_rd)
        bus_rdata <= rdata_next;
    end
  end

  // Registered control decodes
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dac_powerdown_bits <= 4'h0;
      color_bar_enable <= 1'b0;
      force_master <= 1'b0;
      square_pixel_enable <= 1'b0;
      active_line_pixels <= `VMC_LINE_FULL;
      chroma_enable <= 1'b0;
      burst_enable <= 1'b0;
      low_power_enable <= 1'b0;
      vbi_blank <= 1'b1;
      teletext_data <= 1'b0;
      teletext_request <= 1'b0;
      force_black <= 1'b0;
      sync_on_component <= 1'b0;
      vsync_half_lines <= `VMC_VS_NORMAL;
      pedestal_on <= 1'b0;
      blank_filter_on <= 1'b0;
      sleep_enable <= 1'b0;
    end
    else
    begin
      // Order is A, B, D, C from high bit down
      dac_powerdown_bits <= {mr_one[`VMC_B_DAC_A_OFF], mr_one[`VMC_B_DAC_B_OFF],
                             mr_one[`VMC_B_DAC_D_OFF], mr_one[`VMC_B_DAC_C_OFF]};
      color_bar_enable <= mr_one[`VMC_B_COLOR_BAR];
      force_master <= mr_one[`VMC_B_COLOR_BAR];
      square_pixel_enable <= mr_two[`VMC_B_SQUARE_PIXEL] & ~master_timing
                             & ~mr_one[`VMC_B_COLOR_BAR];
      if (!mr_two[`VMC_B_ACTIVE_LINE])
        active_line_pixels <= `VMC_LINE_FULL;
      else
        active_line_pixels <= pal_mode ? `VMC_LINE_PAL : `VMC_LINE_NTSC;
      chroma_enable <= mr_two[`VMC_B_CHROMA];
      burst_enable <= mr_two[`VMC_B_BURST];
      low_power_enable <= mr_two[`VMC_B_LOW_POWER];
      vbi_blank <= ~mr_three[`VMC_B_VBI_PASS] & in_vbi;
      teletext_data <= mr_three[`VMC_B_TTX_ENABLE] & teletext_input_pin;
      // Steady high over window, or one pulse per bit
      teletext_request <= mr_three[`VMC_B_TTX_ENABLE] & teletext_window
                          & (~mr_three[`VMC_B_TTX_STYLE] | teletext_bit_tick);
      force_black <= mr_three[`VMC_B_DEFAULT_COLOR] & pixel_zero;
      sync_on_component <= mr_four[`VMC_B_SYNC_RGB] & comp;
      if (!mr_four[`VMC_B_LONG_VSYNC])
        vsync_half_lines <= `VMC_VS_NORMAL;
      else
        vsync_half_lines <= pal_mode ? `VMC_VS_PAL : `VMC_VS_NTSC;
      pedestal_on <= mr_four[`VMC_B_PEDESTAL] & ~pal_mode;
      blank_filter_on <= mr_four[`VMC_B_FILTER_SW] & ~in_active_video;
      sleep_enable <= mr_four[`VMC_B_SLEEP];
    end
  end

  // Genlock pin direction, role and subcarrier reset pulse
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      genlock_pin_oe <= 1'b0;
      genlock_rtc_in <= 1'b0;
      subcarrier_reset <= 1'b0;
    end
    else
    begin
      // Pin is driven only when not configured as input
      genlock_pin_oe <= ~genlock_in;
      genlock_rtc_in <= genlock_in & mr_two[`VMC_B_GENLOCK_ROLE];
      subcarrier_reset <= sc_fall;
    end
  end

  // DAC source selects, registered from the routing matrix
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dac_a_src <= `VMC_SRC_COMPOSITE_VIDEO;
      dac_b_src <= `VMC_SRC_COMPOSITE_VIDEO;
      dac_c_src <= `VMC_SRC_C;
      dac_d_src <= `VMC_SRC_Y;
    end
    else
    begin
      dac_a_src <= a_next;
      dac_b_src <= b_next;
      dac_c_src <= c_next;
      dac_d_src <= d_next;
    end
  end
endmodule // vmc_mode_bank

// ===== sim/vmc_checker.sv
// Purpose: Port checks of the mode bank
// Assumes: Decodes lag shadows and inputs by one edge
// Notes: Shadows copy every host write to subaddresses 1 to 4
`timescale 1ns/1ns
module vmc_checker
(
  input wire clk,
  input wire nrst,
  input wire [7:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [1:0] revision_in,
  input wire pal_mode,
  input wire master_timing,
  input wire genlock_pin_in,
  input wire teletext_window,
  input wire teletext_bit_tick,
  input wire pixel_zero,
  input wire in_vbi,
  input wire teletext_input_pin,
  input wire in_active_video,
  input wire [7:0] bus_rdata,
  input wire [3:0] dac_powerdown_bits,
  input wire color_bar_enable,
  input wire force_master,
  input wire square_pixel_enable,
  input wire genlock_pin_oe,
  input wire subcarrier_reset,
  input wire [9:0] active_line_pixels,
  input wire vbi_blank,
  input wire teletext_request,
  input wire force_black,
  input wire genlock_rtc_in,
  input wire teletext_data,
  input wire sync_on_component,
  input wire blank_filter_on,
  input wire [2:0] vsync_half_lines,
  input wire pedestal_on,
  input wire sleep_enable
);
  reg [7:0] sh1, sh2, sh3, sh4;
  reg pin_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadow copies of the bank
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {sh1, sh2, sh3, sh4} <= 32'h0;
      pin_d <= 1'b1;
    end
    else
    begin
      pin_d <= genlock_pin_in;
      if (bus_wr && bus_addr == 8'h01) sh1 <= bus_wdata;
      if (bus_wr && bus_addr == 8'h02) sh2 <= bus_wdata;
      if (bus_wr && bus_addr == 8'h03) sh3 <= bus_wdata;
      if (bus_wr && bus_addr == 8'h04) sh4 <= bus_wdata;
    end
  end
  chk_dac_off: assert property ($past(nrst) |->
    dac_powerdown_bits == $past(sh1[6:3])) else $error("dac power-down wrong");
  chk_bar_master: assert property ($past(nrst) |->
    color_bar_enable == $past(sh1[7]) && force_master == color_bar_enable) else $error("bars");
  chk_square_slave: assert property ($past(nrst) |->
    square_pixel_enable == $past(sh2[0] & ~master_timing & ~sh1[7])) else $error("square");
  chk_pin_dir: assert property ($past(nrst) |->
    genlock_pin_oe == !$past(sh2[1])) else $error("pin direction wrong");
  chk_sc_reset: assert property ($past(nrst) |->
    subcarrier_reset == $past(pin_d & ~genlock_pin_in & sh2[1] & ~sh2[2])) else $error("scr");
  chk_line_len: assert property ($past(nrst) |-> active_line_pixels ==
    ($past(sh2[3]) ? ($past(pal_mode) ? 10'h2BE : 10'h2C6) : 10'h2D0)) else $error("line");
  chk_rev_ro: assert property (bus_rd && bus_addr == 8'h03 |=>
    bus_rdata[1:0] == $past(revision_in)) else $error("revision read wrong");
  chk_vbi_pass: assert property ($past(nrst) |->
    vbi_blank == $past(in_vbi & ~sh3[2])) else $error("vbi blank wrong");
  chk_ttx_req: assert property ($past(nrst) |-> teletext_request ==
    $past(sh3[5] & teletext_window & (~sh3[6] | teletext_bit_tick))) else $error("ttx");
  chk_zero_black: assert property ($past(nrst) |->
    force_black == $past(sh3[7] & pixel_zero)) else $error("force black wrong");
  chk_vsync_len: assert property ($past(nrst) |-> vsync_half_lines ==
    ($past(sh4[3]) ? ($past(pal_mode) ? 3'h5 : 3'h6) : 3'h0)) else $error("vsync");
  chk_pedestal_ntsc: assert property ($past(nrst) |->
    pedestal_on == $past(sh4[4] & ~pal_mode)) else $error("pedestal wrong");
  chk_sleep_bit: assert property ($past(nrst) |->
    sleep_enable == $past(sh4[6])) else $error("sleep wrong");
  chk_rtc_role: assert property ($past(nrst) |->
    genlock_rtc_in == $past(sh2[1] & sh2[2])) else $error("rtc role wrong");
  chk_ttx_data: assert property ($past(nrst) |->
    teletext_data == $past(sh3[5] & teletext_input_pin)) else $error("ttx data wrong");
  chk_sync_rgb: assert property ($past(nrst) |->
    sync_on_component == $past(sh4[2] & sh4[0])) else $error("rgb sync wrong");
  chk_filter_blank: assert property ($past(nrst) |->
    blank_filter_on == $past(sh4[5] & ~in_active_video)) else $error("filter switch wrong");
  // Main scenarios seen
  cov_wr_four: cover property (bus_wr && bus_addr == 8'h04);
  cov_sc_reset: cover property (subcarrier_reset);
  cov_ttx_bitwise: cover property (teletext_request && sh3[6]);
endmodule // vmc_checker
bind vmc_mode_bank vmc_checker vmc_checker_inst (.*);

// ===== sim/vmc_host_model.sv
// Purpose: Host side of the register bus
// Assumes: Strobes launched at falling edge
// Notes: Data lines inverted when idle
`timescale 1ns/1ns
module vmc_host_model
(
  input wire clk,
  output reg [7:0] bus_addr,
  output reg [7:0] bus_wdata,
  output reg bus_wr,
  output reg bus_rd,
  input wire [7:0] bus_rdata,
  input wire bus_ack
);
  // Idle bus
  initial
  begin
    {bus_addr, bus_wdata, bus_wr, bus_rd} = 18'h0;
  end
  // One write strobe, reserved top bits cleared
  task wr_reg(input [7:0] a, input [7:0] d, output k);
    begin
      @(negedge clk);
      bus_addr = a;
      bus_wdata = (a == 8'h02 || a == 8'h04) ? {1'b0, d[6:0]} : d;
      bus_wr = 1'b1;
      @(negedge clk);
      k = bus_ack;
      bus_wr = 1'b0;
      bus_wdata = ~bus_wdata;
    end
  endtask
  // One read strobe
  task rd_reg(input [7:0] a, output [7:0] q, output k);
    begin
      @(negedge clk);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge clk);
      q = bus_rdata;
      k = bus_ack;
      bus_rd = 1'b0;
    end
  endtask
endmodule // vmc_host_model

// ===== sim/tb.sv
// Purpose: Random and corner tests of the mode bank
// Assumes: Inputs change at falling edge
// Notes: Decodes checked after two edges
`timescale 1ns/1ns
module tb;
  reg clk, nrst, pal_mode, master_timing, genlock_pin_in, teletext_input_pin;
  reg teletext_window, teletext_bit_tick, pixel_zero, in_active_video, in_vbi, k;
  reg [1:0] revision_in;
  reg [7:0] m [1:4];
  reg [7:0] a, d, q, e;
  reg [31:0] r;
  wire [7:0] bus_addr, bus_wdata, bus_rdata;
  wire bus_wr, bus_rd, bus_ack, color_bar_enable, force_master, square_pixel_enable;
  wire genlock_pin_oe, genlock_rtc_in, subcarrier_reset, chroma_enable, burst_enable;
  wire low_power_enable, vbi_blank, teletext_data, teletext_request, force_black;
  wire sync_on_component, pedestal_on, blank_filter_on, sleep_enable;
  wire [3:0] dac_powerdown_bits;
  wire [9:0] active_line_pixels;
  wire [2:0] vsync_half_lines, dac_a_src, dac_b_src, dac_c_src, dac_d_src;
  integer seed, miscompares, n_compared, cyc, i;
  vmc_mode_bank vmc_mode_bank_inst (.*);
  vmc_host_model host_inst (.*);
  // Expected DAC sources
  function [11:0] route(input [7:0] r3, input [7:0] r4);
    reg [2:0] cv, g;
    begin
      cv = r3[4] ? 3'h2 : 3'h0;
      g = r4[1] ? 3'h1 : 3'h4;
      if (!r4[0])
        route = r3[3] ? {3'h1, 3'h0, 3'h2, cv} : {cv, 3'h0, 3'h2, 3'h1};
      else
        route = r3[3] ? {g, 3'h5, 3'h3, cv} : {cv, 3'h5, 3'h3, g};
    end
  endfunction
  // Compare and count
  task chk(input [15:0] g, input [15:0] x);
    begin
      n_compared = n_compared + 1;
      if (g !== x)
      begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  task print_verdict;
    begin
      if (miscompares == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    cyc = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  // Main sequence
  initial
  begin
    seed = 46442;
    {miscompares, n_compared} = 64'h0;
    {nrst, revision_in, pal_mode, master_timing, teletext_input_pin} = 6'h0;
    {teletext_window, teletext_bit_tick, pixel_zero, in_active_video, in_vbi} = 5'h0;
    genlock_pin_in = 1'b1;
    for (i = 1; i < 5; i = i + 1) m[i] = 8'h00;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    for (i = 0; i < 60; i = i + 1)
    begin
      @(negedge clk);
      r = $random(seed);
      {revision_in, pal_mode, master_timing, genlock_pin_in, teletext_input_pin} = r[5:0];
      {teletext_window, teletext_bit_tick, pixel_zero, in_active_video, in_vbi} = r[10:6];
      a = (i < 6) ? i[7:0] : r[31:24] % 8'd6;
      d = (i < 6) ? 8'hFF : r[23:16];
      host_inst.wr_reg(a, d, k);
      chk(k, a >= 8'h01 && a <= 8'h04);
      if (a >= 8'h01 && a <= 8'h04) m[a] = (a == 8'h02 || a == 8'h04) ? {1'b0, d[6:0]} : d;
      host_inst.rd_reg(a, q, k);
      e = (a < 8'h01 || a > 8'h04) ? 8'h00 : (a == 8'h03) ? {m[3][7:2], revision_in} : m[a];
      chk(q, e);
      @(negedge clk);
      chk(dac_powerdown_bits, m[1][6:3]);
      chk({color_bar_enable, force_master}, {2{m[1][7]}});
      chk(active_line_pixels, m[2][3] ? (pal_mode ? 10'h2BE : 10'h2C6) : 10'h2D0);
      chk(vsync_half_lines, m[4][3] ? (pal_mode ? 3'h5 : 3'h6) : 3'h0);
      chk({dac_a_src, dac_b_src, dac_c_src, dac_d_src}, route(m[3], m[4]));
      chk({low_power_enable, burst_enable, chroma_enable}, m[2][6:4]);
    end
    // Falling pin resets subcarrier once
    host_inst.wr_reg(8'h02, 8'h02, k);
    genlock_pin_in = 1'b1;
    repeat (2) @(negedge clk);
    chk(genlock_pin_oe, 1'b0);
    genlock_pin_in = 1'b0;
    @(negedge clk);
    chk(subcarrier_reset, 1'b1);
    @(negedge clk);
    chk(subcarrier_reset, 1'b0);
    // Reset during sleep
    host_inst.wr_reg(8'h04, 8'h40, k);
    repeat (2) @(negedge clk);
    chk(sleep_enable, 1'b1);
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    host_inst.rd_reg(8'h04, q, k);
    chk({sleep_enable, q}, 9'h000);
    print_verdict;
  end
endmodule // tb
